// ==== hw/hcm_regs.svh ====
// Register offsets, reset values, limits and timing counts
`ifndef HCM_REGS_SVH
`define HCM_REGS_SVH
`define HCM_CTRL_OFS      8'h00
`define HCM_SETP_OFS      8'h04
`define HCM_DBAND_OFS     8'h08
`define HCM_PLIM_OFS      8'h0c
`define HCM_THR_OFS       8'h10
`define HCM_STAT_OFS      8'h14
`define HCM_MERR_OFS      8'h18
`define HCM_MEAS_OFS      8'h1c
`define HCM_CTRL_PROP     0
`define HCM_CTRL_FAHR     1
`define HCM_DB_RST        7'h02
`define HCM_DBF_RST       4'h5
`define HCM_THR_RST       9'h002
`define HCM_FRAME_CYC     10
`define HCM_DUTY_MAX      4'ha
`define HCM_SMP_PER_FRAME 9'h12c
`define HCM_SMP_PER_CYC   30
`define HCM_DB_MIN_C      7'h01
`define HCM_DB_MAX_C      7'h32
`define HCM_DB_MIN_F      7'h02
`define HCM_DB_MAX_F      7'h5a
`define HCM_LIM_MAX       9'h12c
`define HCM_DBF_MIN       4'h1
`define HCM_DBF_MAX       4'ha
`define HCM_HOUR_S        3600
`define HCM_CLK_HZ        20000000
`endif

// ==== hw/hcm_pkg.sv ====
// Types shared by the heater modulation control block
package hcm_pkg;
   typedef enum logic [1:0] {
      HCM_RUN = 2'b00,
      HCM_DIV = 2'b01,
      HCM_ADJ = 2'b11
   } hcm_tune_t;

   typedef struct packed {
      logic        zc_s1;
      logic        zc_s2;
      logic        zc_s3;
      logic [3:0]  cyc_idx;
      logic        frame_ok;
      logic [19:0] per_cnt;
      logic [19:0] period;
      logic [19:0] phase;
      logic [8:0]  smp_cnt;
      logic        adc_start;
      logic [18:0] sum_cur;
      logic [18:0] sum_gf;
      logic [18:0] sum_volt;
      logic [8:0]  cur_avg;
      logic [8:0]  gf_avg;
      logic [8:0]  volt_avg;
      logic [8:0]  cur_prev;
      logic [3:0]  meas_duty;
      logic [3:0]  duty;
      logic [3:0]  duty_act;
      logic        steady;
      logic        gate;
      logic        demand;
      logic [12:0] err;
      logic        prop_en;
      logic        fahr;
      logic [11:0] setp;
      logic [6:0]  db;
      logic [8:0]  lim;
      logic [8:0]  thr;
      hcm_tune_t   tst;
      logic [36:0] hr_cnt;
      logic [31:0] err_sum;
      logic [23:0] rd_cnt;
      logic [23:0] div_d;
      logic [31:0] quo;
      logic [31:0] rem;
      logic [4:0]  div_i;
      logic [15:0] mean;
      logic [15:0] mean_prev;
      logic        have_prev;
      logic        dir_up;
      logic [3:0]  dbf;
      logic        ack;
      logic [31:0] rdata;
   } hcm_state_t;
endpackage

// ==== hw/hcm_pattern.sv ====
// Spreads the conducting cycles of one duty value over the frame
`timescale 1ns/1ps
module hcm_pattern #(
   parameter int FRAME = 10
) (
   input  wire logic [3:0] duty,
   input  wire logic [3:0] idx,
   output logic            on
);
   logic [7:0] prod;
   logic [7:0] rem;

   // Running remainder marks the cycles where a whole step is crossed
   always_comb begin
      prod = 8'({4'h0, duty} * {4'h0, idx});
      rem  = 8'(prod % 8'(FRAME));
      on   = (rem + {4'h0, duty}) >= 8'(FRAME);
   end
endmodule

// ==== hw/hcm_top.sv ====
// Heater cycle modulator, control laws, hourly tuning and bus slave
`timescale 1ns/1ps
`include "hcm_regs.svh"
module hcm_top #(
   parameter longint unsigned HOUR_CYC =
      64'(`HCM_HOUR_S) * 64'(`HCM_CLK_HZ)
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        zero_cross,
   input  wire logic        adc_valid,
   input  wire logic [9:0]  adc_cur,
   input  wire logic [9:0]  adc_gf,
   input  wire logic [9:0]  adc_volt,
   input  wire logic        temp_valid,
   input  wire logic [11:0] temp_val,
   output logic             heater_gate,
   output logic             adc_start,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest
);
   hcm_pkg::hcm_state_t s;
   hcm_pkg::hcm_state_t n;
   logic       zc_evt;
   logic       wrap;
   logic       pat_on;
   logic [3:0] idx_n;
   logic [3:0] pat_duty;
   logic [8:0] cur_new;
   logic [8:0] cur_diff;
   logic       steady_now;
   logic [3:0] cap;

   function automatic logic [3:0] prop_duty(input logic [12:0] e,
                                            input logic [3:0]  f);
      logic [3:0] d;
      d = 4'h0;
      if ($signed(e) <= 0)
         d = 4'h0;
      else if ($signed(e) >= $signed({9'h000, f}))
         d = `HCM_DUTY_MAX;
      else begin
         for (int k = 1; k < 10; k++) begin
            if (({4'h0, e[3:0]} * 8'h0a) >= (8'(k) * {4'h0, f}))
               d = 4'(k);
         end
      end
      return d;
   endfunction

   assign zc_evt   = s.zc_s2 & ~s.zc_s3;
   assign wrap     = zc_evt & (s.cyc_idx == 4'(`HCM_FRAME_CYC - 1));
   assign idx_n    = wrap ? 4'h0 : s.cyc_idx + 4'h1;
   assign pat_duty = wrap ? s.duty : s.duty_act;
   // Full scale 1024 counts is 30 A, so sum of 300 >> 10 is 0.1 A units
   assign cur_new  = s.sum_cur[18:10];
   assign cur_diff = (cur_new > s.cur_prev) ? cur_new - s.cur_prev
                                            : s.cur_prev - cur_new;
   // Pending duty must be in force before the loop may step again
   assign steady_now = (s.duty == s.duty_act)
                       && (s.duty_act == s.meas_duty)
                       && (cur_diff < s.thr);
   // Mode selects the duty ceiling; prop shares the modulator
   assign cap = s.prop_en ? prop_duty(s.err, s.dbf)
                          : (s.demand ? `HCM_DUTY_MAX : 4'h0);

   hcm_pattern #(
      .FRAME (`HCM_FRAME_CYC)
   ) u_pat (
      .duty (pat_duty),
      .idx  (idx_n),
      .on   (pat_on)
   );

   always_comb begin
      logic [20:0] ph;
      logic [12:0] e_now;
      logic [12:0] abs_e;
      logic [13:0] t14;
      logic [13:0] lo;
      logic [13:0] hi;
      logic [31:0] r2;
      logic [6:0]  wd7;
      logic [6:0]  dlo;
      logic [6:0]  dhi;
      logic        d_up;
      ph    = {1'b0, s.phase} + 21'(`HCM_SMP_PER_CYC);
      e_now = {s.setp[11], s.setp} - {temp_val[11], temp_val};
      abs_e = e_now[12] ? 13'h0 - e_now : e_now;
      t14   = {{2{temp_val[11]}}, temp_val};
      lo    = {{2{s.setp[11]}}, s.setp} - {7'h00, s.db};
      hi    = {{2{s.setp[11]}}, s.setp} + {7'h00, s.db};
      r2    = {s.rem[30:0], s.quo[31]};
      wd7   = (avs_writedata[31:7] != 25'h0) ? 7'h7f : avs_writedata[6:0];
      dlo   = s.fahr ? `HCM_DB_MIN_F : `HCM_DB_MIN_C;
      dhi   = s.fahr ? `HCM_DB_MAX_F : `HCM_DB_MAX_C;
      d_up  = s.dir_up;
      n     = s;

      // Pin synchroniser and mains period measurement
      n.zc_s1     = zero_cross;
      n.zc_s2     = s.zc_s1;
      n.zc_s3     = s.zc_s2;
      n.adc_start = 1'b0;
      if (s.per_cnt != 20'hfffff)
         n.per_cnt = s.per_cnt + 20'h1;

      // Thirty sample strobes per mains period, phase accumulator
      if (s.frame_ok && s.period != 20'h0
          && s.smp_cnt < `HCM_SMP_PER_FRAME) begin
         if (ph >= {1'b0, s.period}) begin
            n.phase     = 20'(ph - {1'b0, s.period});
            n.adc_start = 1'b1;
            n.smp_cnt   = s.smp_cnt + 9'h1;
         end else begin
            n.phase = ph[19:0];
         end
      end
      if (adc_valid) begin
         n.sum_cur  = s.sum_cur + {9'h000, adc_cur};
         n.sum_gf   = s.sum_gf + {9'h000, adc_gf};
         n.sum_volt = s.sum_volt + {9'h000, adc_volt};
      end

      if (zc_evt) begin
         n.period  = s.per_cnt + 20'h1;
         n.per_cnt = 20'h0;
         n.cyc_idx = idx_n;
         n.gate    = pat_on;
         if (wrap) begin
            n.frame_ok  = 1'b1;
            n.duty_act  = s.duty;
            n.phase     = 20'h0;
            n.smp_cnt   = 9'h0;
            n.sum_cur   = 19'h0;
            n.sum_gf    = 19'h0;
            n.sum_volt  = 19'h0;
            n.cur_avg   = cur_new;
            n.gf_avg    = s.sum_gf[18:10];
            n.volt_avg  = s.sum_volt[18:10];
            n.cur_prev  = cur_new;
            n.meas_duty = s.duty_act;
            n.steady    = steady_now;
            if (s.lim == 9'h0)
               n.duty = cap;
            else if (cap == 4'h0)
               n.duty = 4'h0;
            else if (s.duty > cap)
               n.duty = cap;
            else if (steady_now) begin
               if (cur_new > s.lim && s.duty != 4'h0)
                  n.duty = s.duty - 4'h1;
               else if (cur_new < s.lim && s.duty < cap)
                  n.duty = s.duty + 4'h1;
            end
         end
      end

      // Temperature readings: hysteresis and error accumulation
      if (temp_valid) begin
         n.err = e_now;
         if ($signed(t14) > $signed(hi) || (s.db != 7'h0 && t14 == hi))
            n.demand = 1'b0;
         else if ($signed(t14) < $signed(lo)
                  || (s.db != 7'h0 && t14 == lo))
            n.demand = 1'b1;
         n.err_sum = s.err_sum + {19'h0, abs_e};
         n.rd_cnt  = s.rd_cnt + 24'h1;
      end

      // Hourly deadband factor tuning
      n.hr_cnt = s.hr_cnt + 37'h1;
      case (s.tst)
         hcm_pkg::HCM_RUN: begin
            if (s.hr_cnt == 37'(HOUR_CYC - 64'h1)) begin
               n.hr_cnt  = 37'h0;
               n.err_sum = 32'h0;
               n.rd_cnt  = 24'h0;
               if (s.rd_cnt != 24'h0) begin
                  n.quo   = s.err_sum;
                  n.rem   = 32'h0;
                  n.div_d = s.rd_cnt;
                  n.div_i = 5'h0;
                  n.tst   = hcm_pkg::HCM_DIV;
               end
            end
         end
         hcm_pkg::HCM_DIV: begin
            n.quo   = {s.quo[30:0], 1'b0};
            n.rem   = r2;
            if (r2 >= {8'h00, s.div_d}) begin
               n.rem    = r2 - {8'h00, s.div_d};
               n.quo[0] = 1'b1;
            end
            n.div_i = s.div_i + 5'h1;
            if (s.div_i == 5'h1f)
               n.tst = hcm_pkg::HCM_ADJ;
         end
         hcm_pkg::HCM_ADJ: begin
            n.mean = (s.quo[31:16] != 16'h0) ? 16'hffff : s.quo[15:0];
            if (s.have_prev && n.mean > s.mean_prev)
               d_up = ~s.dir_up;
            n.dir_up    = d_up;
            n.mean_prev = n.mean;
            n.have_prev = 1'b1;
            if (d_up && s.dbf < `HCM_DBF_MAX)
               n.dbf = s.dbf + 4'h1;
            else if (!d_up && s.dbf > `HCM_DBF_MIN)
               n.dbf = s.dbf - 4'h1;
            n.tst = hcm_pkg::HCM_RUN;
         end
         default: n.tst = hcm_pkg::HCM_RUN;
      endcase

      // Bus slave: one wait cycle, then answer
      n.ack = (avs_read | avs_write) & ~s.ack;
      if (avs_read && !s.ack) begin
         case (avs_address)
            `HCM_CTRL_OFS:  n.rdata = {30'h0, s.fahr, s.prop_en};
            `HCM_SETP_OFS:  n.rdata = {{20{s.setp[11]}}, s.setp};
            `HCM_DBAND_OFS: n.rdata = {25'h0, s.db};
            `HCM_PLIM_OFS:  n.rdata = {23'h0, s.lim};
            `HCM_THR_OFS:   n.rdata = {23'h0, s.thr};
            `HCM_STAT_OFS:  n.rdata = {12'h0, s.cyc_idx, s.dbf, s.dir_up,
                                       s.steady, s.demand, s.gate,
                                       s.duty_act, s.duty};
            `HCM_MERR_OFS:  n.rdata = {s.mean_prev, s.mean};
            `HCM_MEAS_OFS:  n.rdata = {5'h0, s.volt_avg, s.gf_avg,
                                       s.cur_avg};
            default:        n.rdata = 32'h0;
         endcase
      end
      if (avs_write && s.ack) begin
         case (avs_address)
            `HCM_CTRL_OFS: begin
               n.prop_en = avs_writedata[`HCM_CTRL_PROP];
               n.fahr    = avs_writedata[`HCM_CTRL_FAHR];
            end
            `HCM_SETP_OFS: n.setp = avs_writedata[11:0];
            `HCM_DBAND_OFS: begin
               if (wd7 == 7'h0)
                  n.db = 7'h0;
               else if (wd7 < dlo)
                  n.db = dlo;
               else if (wd7 > dhi)
                  n.db = dhi;
               else
                  n.db = wd7;
            end
            `HCM_PLIM_OFS: begin
               if (avs_writedata[31:9] != 23'h0
                   || avs_writedata[8:0] > `HCM_LIM_MAX)
                  n.lim = `HCM_LIM_MAX;
               else
                  n.lim = avs_writedata[8:0];
            end
            `HCM_THR_OFS: n.thr = avs_writedata[8:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         s     <= '0;
         s.db  <= `HCM_DB_RST;
         s.dbf <= `HCM_DBF_RST;
         s.thr <= `HCM_THR_RST;
      end else begin
         s <= n;
      end
   end

   assign heater_gate     = s.gate;
   assign adc_start       = s.adc_start;
   assign avs_readdata    = s.rdata;
   assign avs_waitrequest = (avs_read | avs_write) & ~s.ack;

   logic [13:0] t14_chk;
   logic [13:0] hi_chk;
   assign t14_chk = {{2{temp_val[11]}}, temp_val};
   assign hi_chk  = {{2{s.setp[11]}}, s.setp} + {7'h00, s.db};

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   property p_frame_idx;
      s.cyc_idx < 4'(`HCM_FRAME_CYC);
   endproperty
   a_frame_idx: assert property (p_frame_idx)
      else $error("cycle index left the frame");

   property p_duty_frame;
      $changed(s.duty_act) |-> $past(wrap);
   endproperty
   a_duty_frame: assert property (p_duty_frame)
      else $error("applied duty changed inside a frame");

   property p_duty_max;
      s.duty <= `HCM_DUTY_MAX && s.duty_act <= `HCM_DUTY_MAX;
   endproperty
   a_duty_max: assert property (p_duty_max)
      else $error("duty above full");

   property p_gate_zc;
      $changed(s.gate) |-> $past(zc_evt);
   endproperty
   a_gate_zc: assert property (p_gate_zc)
      else $error("gate switched away from a zero crossing");

   property p_lim_down;
      wrap && s.lim != 9'h0 && cap != 4'h0 && s.duty <= cap && steady_now
      && cur_new > s.lim && s.duty != 4'h0
      |=> s.duty == $past(s.duty) - 4'h1;
   endproperty
   a_lim_down: assert property (p_lim_down)
      else $error("duty not lowered above the limit");

   property p_lim_up;
      wrap && s.lim != 9'h0 && s.duty < cap && steady_now
      && cur_new < s.lim
      |=> s.duty == $past(s.duty) + 4'h1;
   endproperty
   a_lim_up: assert property (p_lim_up)
      else $error("duty not raised below the limit");

   property p_hold_unsteady;
      wrap && s.lim != 9'h0 && cap != 4'h0 && s.duty <= cap && !steady_now
      |=> $stable(s.duty);
   endproperty
   a_hold_unsteady: assert property (p_hold_unsteady)
      else $error("duty stepped before current settled");

   property p_soft_start;
      wrap && s.lim != 9'h0 && s.duty == 4'h0 |=> s.duty <= 4'h1;
   endproperty
   a_soft_start: assert property (p_soft_start)
      else $error("duty jumped from zero");

   property p_samples;
      s.smp_cnt <= `HCM_SMP_PER_FRAME;
   endproperty
   a_samples: assert property (p_samples)
      else $error("too many samples in a frame");

   property p_prop_zero;
      s.prop_en && $signed(s.err) <= 0 |-> cap == 4'h0;
   endproperty
   a_prop_zero: assert property (p_prop_zero)
      else $error("proportional duty with no error");

   property p_dbf;
      s.dbf >= `HCM_DBF_MIN && s.dbf <= `HCM_DBF_MAX
      && (!$changed(s.dbf) || $past(s.tst) == hcm_pkg::HCM_ADJ);
   endproperty
   a_dbf: assert property (p_dbf)
      else $error("deadband factor out of range or off schedule");

   property p_mode_write;
      $rose(s.prop_en) |-> $past(avs_write && s.ack
                                  && avs_address == `HCM_CTRL_OFS);
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("proportional mode set without a write");

   property p_demand_off;
      $fell(s.demand) |-> $past(temp_valid)
         && $past($signed(t14_chk) >= $signed(hi_chk));
   endproperty
   a_demand_off: assert property (p_demand_off)
      else $error("demand removed below upper band");

   property p_db_range;
      s.db <= `HCM_DB_MAX_F;
   endproperty
   a_db_range: assert property (p_db_range)
      else $error("deadband out of range");

   property p_lim_range;
      s.lim <= `HCM_LIM_MAX;
   endproperty
   a_lim_range: assert property (p_lim_range)
      else $error("current limit out of range");

   c_half: cover property (wrap && s.duty == 4'h5);
   c_steady: cover property (wrap && steady_now && s.lim != 9'h0);
   c_tune: cover property (s.tst == hcm_pkg::HCM_ADJ);
   c_demand: cover property ($rose(s.demand));
endmodule

// ==== test/hcm_mains_model.sv ====
// Mains zero-cross source and heater switch with converter
`timescale 1ns/1ps
module hcm_mains_model #(
   parameter int HALF = 60,
   parameter int CONV = 2
) (
   input  wire logic       sys_clk,
   input  wire logic       heater_gate,
   input  wire logic       adc_start,
   output logic            zero_cross,
   output logic            adc_valid,
   output logic [9:0]      adc_cur,
   output logic [9:0]      adc_gf,
   output logic [9:0]      adc_volt
);
   int         ph;
   int         cv;
   logic [9:0] junk;
   initial begin
      zero_cross = 1'b0;
      adc_valid  = 1'b0;
      adc_cur    = 10'h000;
      adc_gf     = 10'h000;
      adc_volt   = 10'h000;
      junk       = 10'h155;
      ph         = 0;
      cv         = 0;
   end
   always @(posedge sys_clk) begin
      ph   <= (ph == HALF - 1) ? 0 : ph + 1;
      junk <= {junk[8:0], ~junk[9]};
      if (ph == HALF - 1)
         zero_cross <= ~zero_cross;
      cv        <= adc_start ? CONV : (cv > 0 ? cv - 1 : 0);
      adc_valid <= (cv == 1);
      // Current only while conducting; idle lines keep moving
      adc_cur  <= (cv == 1) ? (heater_gate ? 10'h3e8 : 10'h000) : junk;
      adc_gf   <= (cv == 1) ? 10'h004 : ~junk;
      adc_volt <= (cv == 1) ? 10'h200 : junk ^ 10'h2aa;
   end
endmodule

// ==== test/hcm_top_tb.sv ====
// Self-checking bench for the heater cycle modulator
`timescale 1ns/1ps
`include "hcm_regs.svh"
module hcm_top_tb;
   localparam int HALF  = 60;
   localparam int FRAME = 20 * HALF;
   logic        sys_clk;
   logic        rstn;
   logic        zero_cross;
   logic        adc_valid;
   logic [9:0]  adc_cur;
   logic [9:0]  adc_gf;
   logic [9:0]  adc_volt;
   logic        temp_valid;
   logic [11:0] temp_val;
   logic        heater_gate;
   logic        adc_start;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [31:0] rd;
   logic        zc_d;
   logic        gate_d;
   int          zc_age;
   int          fails;
   int          compares;

   // Short hour: first ends after the last reading of t_plim
   hcm_top #(.HOUR_CYC(64'd45000)) i_dut (.sys_clk, .rstn,
      .zero_cross, .adc_valid, .adc_cur, .adc_gf, .adc_volt,
      .temp_valid, .temp_val, .heater_gate, .adc_start, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest);
   hcm_mains_model #(.HALF(HALF)) i_mains (.sys_clk, .heater_gate,
      .adc_start, .zero_cross, .adc_valid, .adc_cur, .adc_gf, .adc_volt);

   initial sys_clk = 1'b0;
   always #25 sys_clk = ~sys_clk;

   task automatic summarize();
      $display("Comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk_eq(input string w, input logic [31:0] e,
                         input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %0h seen %0h", w, e, g);
      end
   endtask

   task automatic chk_rng(input string w, input logic [31:0] lo,
                          input logic [31:0] hi, input logic [31:0] g);
      logic ok;
      ok = (g >= lo) && (g <= hi);
      compares++;
      if (ok !== 1'b1) begin
         fails++;
         $display("CHECK FAILED %s expected %0h..%0h seen %0h", w, lo, hi, g);
      end
   endtask

   // Gate may move only just after a rising zero crossing
   always @(posedge sys_clk) begin
      zc_d   <= zero_cross;
      gate_d <= heater_gate;
      zc_age <= (zero_cross && !zc_d) ? 0 : zc_age + 1;
      if (rstn && heater_gate !== gate_d)
         chk_rng("gate_edge_age", 0, 8, zc_age);
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic wait_zc();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (!(zero_cross === 1'b1 && zc_d === 1'b0) && n < 4 * HALF);
      if (n >= 4 * HALF) begin
         fails++;
         summarize();
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) begin
         fails++;
         summarize();
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic set_temp(input logic [11:0] t);
      @(posedge sys_clk);
      temp_val   <= t;
      temp_valid <= 1'b1;
      @(posedge sys_clk);
      temp_valid <= 1'b0;
   endtask

   task automatic t_reset();
      bus(0, `HCM_CTRL_OFS, 0);
      chk_eq("ctrl", 32'h0, rd);
      bus(0, `HCM_DBAND_OFS, 0);
      chk_eq("dband", 32'(`HCM_DB_RST), rd);
      bus(0, `HCM_STAT_OFS, 0);
      chk_eq("factor", 32'(`HCM_DBF_RST), 32'(rd[15:12]));
      bus(1, 8'h40, 32'hffffffff);
      bus(0, 8'h40, 0);
      chk_eq("unmapped", 32'h0, rd);
   endtask

   task automatic t_clamp();
      bus(1, `HCM_DBAND_OFS, 32'h3c);
      bus(0, `HCM_DBAND_OFS, 0);
      chk_eq("dband_c_max", 32'h32, rd);
      bus(1, `HCM_CTRL_OFS, 32'h2);
      bus(1, `HCM_DBAND_OFS, 32'h1);
      bus(0, `HCM_DBAND_OFS, 0);
      chk_eq("dband_f_min", 32'h2, rd);
      bus(1, `HCM_CTRL_OFS, 32'h0);
      bus(1, `HCM_PLIM_OFS, 32'h190);
      bus(0, `HCM_PLIM_OFS, 0);
      chk_eq("plim_max", 32'h12c, rd);
      bus(1, `HCM_PLIM_OFS, 32'h0);
   endtask

   task automatic t_deadband();
      logic [11:0] tv [8] = '{12'h05a, 12'h065, 12'h066, 12'h063,
                              12'h062, 12'h063, 12'h065, 12'h063};
      logic        de [8] = '{1'b1, 1'b1, 1'b0, 1'b0,
                              1'b1, 1'b1, 1'b0, 1'b1};
      bus(1, `HCM_SETP_OFS, 32'h64);
      bus(1, `HCM_DBAND_OFS, 32'h2);
      for (int i = 0; i < 8; i++) begin
         if (i == 5)
            bus(1, `HCM_DBAND_OFS, 32'h0);
         set_temp(tv[i]);
         bus(0, `HCM_STAT_OFS, 0);
         chk_eq("demand", 32'(de[i]), 32'(rd[9]));
      end
   endtask

   task automatic t_adc();
      int n;
      wait_clk(3 * FRAME);
      wait_zc();
      n = 0;
      repeat (FRAME) begin
         @(posedge sys_clk);
         n += int'(adc_start === 1'b1);
      end
      chk_rng("starts_per_frame", 285, 300, n);
      bus(0, `HCM_MEAS_OFS, 0);
      chk_rng("cur_avg_full", 285, 293, 32'(rd[8:0]));
   endtask

   task automatic chk_frame(input logic [3:0] n);
      int i;
      logic on;
      int cnt;
      cnt = 0;
      wait_clk(3 * FRAME);
      wait_zc();
      wait_clk(40);
      bus(0, `HCM_STAT_OFS, 0);
      chk_eq("duty_applied", 32'(n), 32'(rd[7:4]));
      for (int k = 0; k < 10; k++) begin
         if (k > 0) begin
            wait_zc();
            wait_clk(40);
         end
         i  = (int'(rd[19:16]) + k) % 10;
         // Cycle conducts where the running share crosses a whole step
         on = ((i + 1) * int'(n)) / 10 > (i * int'(n)) / 10;
         cnt += int'(heater_gate === 1'b1);
         chk_eq("gate_cycle", 32'(on), 32'(heater_gate));
      end
      chk_eq("gate_on_count", 32'(n), 32'(cnt));
   endtask

   task automatic t_prop();
      logic [11:0] tv [7] = '{12'h064, 12'h063, 12'h062, 12'h061,
                              12'h060, 12'h05f, 12'h06e};
      logic [3:0]  du [7] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'h0};
      bus(1, `HCM_CTRL_OFS, 32'h1);
      for (int i = 0; i < 7; i++) begin
         set_temp(tv[i]);
         chk_frame(du[i]);
      end
   endtask

   task automatic t_plim();
      int prev;
      int d;
      int last;
      bus(1, `HCM_CTRL_OFS, 32'h0);
      bus(1, `HCM_DBAND_OFS, 32'h2);
      bus(1, `HCM_THR_OFS, 32'h0a);
      bus(1, `HCM_PLIM_OFS, 32'h64);
      set_temp(12'h078);
      wait_clk(2 * FRAME);
      set_temp(12'h032);
      prev = 0;
      last = -1;
      for (int p = 0; p < 50; p++) begin
         wait_clk(FRAME / 2);
         bus(0, `HCM_STAT_OFS, 0);
         d = int'(rd[7:4]);
         chk_rng("duty_step", prev > 0 ? prev - 1 : 0, prev + 1, d);
         chk_rng("duty_ceiling", 0, 4, d);
         if (d != prev && last >= 0)
            chk_rng("polls_between_steps", 3, 99, p - last);
         if (d != prev)
            last = p;
         prev = d;
      end
      chk_rng("duty_settled", 3, 4, prev);
   endtask

   // Hour one: 17 readings, abs errors sum 114; first step goes down
   task automatic t_tune();
      bus(0, `HCM_STAT_OFS, 0);
      chk_eq("factor_hour1", 32'h4, 32'(rd[15:12]));
      bus(0, `HCM_MERR_OFS, 0);
      chk_eq("mean_hour1", 32'h6, 32'(rd[15:0]));
      set_temp(12'h064);
      set_temp(12'h064);
      wait_clk(20000);
      bus(0, `HCM_STAT_OFS, 0);
      chk_eq("factor_hour2", 32'h3, 32'(rd[15:12]));
      bus(0, `HCM_MERR_OFS, 0);
      chk_eq("mean_hour2", 32'h0, 32'(rd[15:0]));
   endtask

   initial begin
      rstn          = 1'b0;
      temp_valid    = 1'b0;
      temp_val      = 12'h000;
      avs_address   = 8'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0;
      wait_clk(10);
      rstn <= 1'b1;
      t_reset();
      t_clamp();
      t_deadband();
      t_adc();
      t_prop();
      t_plim();
      t_tune();
      summarize();
   end
endmodule
